//--- verilog/emf_top.sv
// ethernet mac fifo forwarding, port management and buffer checks
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - phy management settings apply only while the general port is selected.
// - unselected, management writes are dropped; reads return zero.
// - receive store-and-forward: dma starts only after the frame's last word.
// - receive cut-through: dma starts once threshold words sit in the fifo.
// - transmit store-and-forward: sending waits for the written frame end.
// - cpu or mac dma writes to unsecured buffers raise an interrupt.
// - buffer ram dma stray access gives interrupt or result code by call kind.
// - long acquire address is prefix, 3'b100, long index, zeros.
// - short acquire address is prefix, 2'b00, short index, zeros.
module emf_top #(
	parameter int RX_CNT_W = 12,
	parameter int TX_CNT_W = 12,
	parameter int LONG_N   = 64,
	parameter int SHORT_N  = 128
) (
	input  wire logic                      ref_clk,
	input  wire logic                      arst_n,
	input  wire logic [emf_pkg::ADDR_W-1:0] avs_address,
	input  wire logic                      avs_read,
	input  wire logic                      avs_write,
	input  wire logic [31:0]               avs_writedata,
	input  wire logic [3:0]                avs_byteenable,
	output logic [31:0]                    avs_readdata,
	output logic                           avs_waitrequest,
	input  wire logic                      rx_word_wr,
	input  wire logic                      rx_frame_end,
	output logic                           rx_dma_start,
	input  wire logic                      tx_word_wr,
	input  wire logic                      tx_frame_end,
	output logic                           tx_start,
	output logic                           tx_long_frame_en,
	output logic                           switch_tag_en,
	output logic [31:0]                    phy_mgmt_ctrl,
	input  wire logic                      acc_valid,
	input  wire logic [31:0]               acc_addr,
	input  wire emf_pkg::emf_src_t         acc_src,
	output logic                           irq
);
	import emf_pkg::*;

	logic [31:0]      receive_mode_control_r;
	logic [31:0]      transmit_mode_control_r;
	logic [31:0]      mac_port_select_r;
	logic [31:0]      phy_mgmt_ctrl_reg_r;
	logic [31:0]      switch_mgmt_tag_ctrl_r;
	logic [INT_W-1:0] int_stat_r, int_stat_nxt;
	logic [INT_W-1:0] int_mask_r;
	logic [INT_W-1:0] int_events;
	logic [INT_W-1:0] int_clear;
	logic [RES_W-1:0] call_result_register_r, call_res_nxt;
	logic [RES_W-1:0] res_events;
	logic [RES_W-1:0] res_clear;
	logic [31:0]      acq_addr_r;
	logic [31:0]      rd_mux;
	logic             acq_long_r;
	logic             acq_short_r;
	logic             rel_r;
	logic [31:0]      rel_addr_r;
	logic             wr_go;
	logic             rd_take;
	logic             gp_selected;
	logic             stray_any;

	emf_alloc_if alloc_bus ();

	// byte-lane merge of a write into a held register
	function automatic logic [31:0] be_merge(input logic [31:0] old,
		input logic [31:0] wdata, input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) res[b*8 +: 8] = wdata[b*8 +: 8];
		end
		return res;
	endfunction : be_merge

	// address compare shared by every register write
	function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] ofs);
		return a == ofs;
	endfunction : reg_hit

	// a write lands only on the edge where waitrequest is seen low
	assign wr_go = avs_write && !avs_waitrequest;
	assign rd_take = avs_read && avs_waitrequest;
	assign gp_selected = mac_port_select_r[PORT_GP_BIT];

	// one wait cycle per access, then waitrequest drops for one cycle
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
		end
	end

	// receive mode register, only documented bits are writable
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			receive_mode_control_r <= RX_MODE_RST;
		end else if (wr_go && reg_hit(avs_address, OFS_RX_MODE)) begin
			receive_mode_control_r <= RX_MODE_WMASK & be_merge(
				receive_mode_control_r, avs_writedata, avs_byteenable);
		end
	end

	// transmit mode register; resets to store-and-forward for safety
	// a zero mode bit runs cut-through; software is not allowed to use it
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			transmit_mode_control_r <= TX_MODE_RST;
		end else if (wr_go && reg_hit(avs_address, OFS_TX_MODE)) begin
			transmit_mode_control_r <= TX_MODE_WMASK & be_merge(
				transmit_mode_control_r, avs_writedata, avs_byteenable);
		end
	end

	// port selection and switch tag control
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			mac_port_select_r <= '0;
			switch_mgmt_tag_ctrl_r <= '0;
		end else if (wr_go) begin
			if (reg_hit(avs_address, OFS_PORT_SEL))
				mac_port_select_r <= be_merge(mac_port_select_r,
					avs_writedata, avs_byteenable);
			if (reg_hit(avs_address, OFS_SW_TAG))
				switch_mgmt_tag_ctrl_r <= be_merge(switch_mgmt_tag_ctrl_r,
					avs_writedata, avs_byteenable);
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			phy_mgmt_ctrl_reg_r <= '0;
		end else if (wr_go && reg_hit(avs_address, OFS_PHY_MGMT)
			&& gp_selected) begin
			phy_mgmt_ctrl_reg_r <= be_merge(phy_mgmt_ctrl_reg_r,
				avs_writedata, avs_byteenable);
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			phy_mgmt_ctrl <= '0;
		end else if (gp_selected) begin
			phy_mgmt_ctrl <= phy_mgmt_ctrl_reg_r;
		end
	end

	// level outputs for the transmit path; software owns their pairing
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_long_frame_en <= 1'b0;
			switch_tag_en <= 1'b0;
		end else begin
			tx_long_frame_en <= transmit_mode_control_r[TX_LFE_BIT];
			switch_tag_en <= switch_mgmt_tag_ctrl_r[SW_TAG_BIT];
		end
	end

	emf_fwd_gate #(
		.CNT_W     (RX_CNT_W),
		.THR_W     (RX_THR_W)
	) u_rx_gate (
		.ref_clk   (ref_clk),
		.arst_n    (arst_n),
		.saf_mode  (receive_mode_control_r[MODE_SAF_BIT]),
		.start_thr (receive_mode_control_r[RX_THR_LSB +: RX_THR_W]),
		.word_wr   (rx_word_wr),
		.frame_end (rx_frame_end),
		.start_r   (rx_dma_start)
	);

	emf_fwd_gate #(
		.CNT_W     (TX_CNT_W),
		.THR_W     (TX_THR_W)
	) u_tx_gate (
		.ref_clk   (ref_clk),
		.arst_n    (arst_n),
		.saf_mode  (transmit_mode_control_r[MODE_SAF_BIT]),
		.start_thr (transmit_mode_control_r[TX_THR_LSB +: TX_THR_W]),
		.word_wr   (tx_word_wr),
		.frame_end (tx_frame_end),
		.start_r   (tx_start)
	);

	// call commands become one-cycle pulses toward the allocator
	// both call bits together: the allocator serves the long request
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			acq_long_r <= 1'b0;
			acq_short_r <= 1'b0;
			rel_r <= 1'b0;
			rel_addr_r <= '0;
		end else begin
			acq_long_r <= wr_go && reg_hit(avs_address, OFS_CALL)
				&& avs_writedata[CALL_LONG_BIT];
			acq_short_r <= wr_go && reg_hit(avs_address, OFS_CALL)
				&& avs_writedata[CALL_SHRT_BIT];
			rel_r <= wr_go && reg_hit(avs_address, OFS_RELEASE);
			if (wr_go && reg_hit(avs_address, OFS_RELEASE))
				rel_addr_r <= avs_writedata;
		end
	end

	// pulses and the checked address travel to the allocator
	assign alloc_bus.acq_long = acq_long_r;
	assign alloc_bus.acq_short = acq_short_r;
	assign alloc_bus.rel_valid = rel_r;
	assign alloc_bus.rel_addr = rel_addr_r;
	assign alloc_bus.chk_addr = acc_addr;

	emf_buf_alloc #(
		.LONG_N  (LONG_N),
		.SHORT_N (SHORT_N)
	) u_alloc (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.bus     (alloc_bus)
	);

	// last granted start address, kept until the next grant
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			acq_addr_r <= '0;
		end else if (alloc_bus.rsp_valid && alloc_bus.rsp_ok) begin
			acq_addr_r <= alloc_bus.rsp_addr;
		end
	end

	// stray access: a pool address whose slot nobody owns
	assign stray_any = acc_valid && alloc_bus.chk_unsec;

	// event sources; clears are write-one, set beats clear
	always_comb begin
		int_events = '0;
		int_events[INT_RX_START] = rx_dma_start;
		int_events[INT_TX_START] = tx_start;
		int_events[INT_UNSEC_WR] = stray_any
			&& (acc_src == SRC_CPU || acc_src == SRC_MAC_DMA);
		int_events[INT_BR_UNSEC] = stray_any && acc_src == SRC_BR_INTBUF;
		// a failed acquire is also coded in the result register
		int_events[INT_NO_BUF] = alloc_bus.rsp_valid && !alloc_bus.rsp_ok;
		int_clear = '0;
		if (wr_go && reg_hit(avs_address, OFS_INT_STAT))
			int_clear = avs_writedata[INT_W-1:0];
		int_stat_nxt = (int_stat_r & ~int_clear) | int_events;
	end

	// sticky interrupt status and its mask
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			int_stat_r <= '0;
			int_mask_r <= '0;
		end else begin
			int_stat_r <= int_stat_nxt;
			if (wr_go && reg_hit(avs_address, OFS_INT_MASK))
				int_mask_r <= avs_writedata[INT_W-1:0];
		end
	end

	// level interrupt from next status so it tracks the sticky bits
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(int_stat_nxt & int_mask_r);
		end
	end

	// result codes of calls; write-one clears, hardware set wins
	always_comb begin
		res_events = '0;
		// result bit 1 is never coded by this block
		// transfer-style calls, then failed acquires
		res_events[RES_VIOL_BIT] = stray_any && acc_src == SRC_BR_XFER;
		res_events[RES_NOBUF_BIT] = alloc_bus.rsp_valid
			&& !alloc_bus.rsp_ok;
		res_clear = '0;
		if (wr_go && reg_hit(avs_address, OFS_CALL_RES))
			res_clear = avs_writedata[RES_W-1:0];
		call_res_nxt = (call_result_register_r & ~res_clear) | res_events;
	end

	// result codes stay until software clears them
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			call_result_register_r <= '0;
		end else begin
			call_result_register_r <= call_res_nxt;
		end
	end

	// read mux; unmapped offsets read as zero
	always_comb begin
		rd_mux = '0;
		case (avs_address)
			OFS_RX_MODE:  rd_mux = receive_mode_control_r;
			OFS_TX_MODE:  rd_mux = transmit_mode_control_r;
			OFS_PORT_SEL: rd_mux = mac_port_select_r;
			OFS_PHY_MGMT: rd_mux = gp_selected ? phy_mgmt_ctrl_reg_r : '0;
			OFS_SW_TAG:   rd_mux = switch_mgmt_tag_ctrl_r;
			// status and result fields are narrower than the bus
			OFS_INT_STAT: rd_mux = {{(32-INT_W){1'b0}}, int_stat_r};
			OFS_INT_MASK: rd_mux = {{(32-INT_W){1'b0}}, int_mask_r};
			OFS_CALL_RES: rd_mux = {{(32-RES_W){1'b0}},
				call_result_register_r};
			OFS_ACQ_ADDR: rd_mux = acq_addr_r;
			default:      rd_mux = '0;
		endcase
	end

	// read data captured in the wait cycle, stands at the accepting edge
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			avs_readdata <= '0;
		end else if (rd_take) begin
			avs_readdata <= rd_mux;
		end
	end
endmodule : emf_top
`default_nettype wire

//--- verilog/emf_pkg.sv
// shared constants and types for the mac forwarding and buffer block
package emf_pkg;
	// register byte offsets on the avalon slave
	localparam int         ADDR_W       = 6;
	localparam logic [5:0] OFS_RX_MODE  = 6'h00;
	localparam logic [5:0] OFS_TX_MODE  = 6'h04;
	localparam logic [5:0] OFS_PORT_SEL = 6'h08;
	localparam logic [5:0] OFS_PHY_MGMT = 6'h0c;
	localparam logic [5:0] OFS_SW_TAG   = 6'h10;
	localparam logic [5:0] OFS_INT_STAT = 6'h14;
	localparam logic [5:0] OFS_INT_MASK = 6'h18;
	localparam logic [5:0] OFS_CALL     = 6'h1c;
	localparam logic [5:0] OFS_RELEASE  = 6'h20;
	localparam logic [5:0] OFS_CALL_RES = 6'h24;
	localparam logic [5:0] OFS_ACQ_ADDR = 6'h28;
	// mode and control fields
	localparam int MODE_SAF_BIT  = 29;
	localparam int RX_THR_LSB    = 0;
	localparam int RX_THR_W      = 3;
	localparam int TX_THR_LSB    = 0;
	localparam int TX_THR_W      = 2;
	localparam int TX_LFE_BIT    = 4;
	localparam int SW_TAG_BIT    = 0;
	localparam int PORT_GP_BIT   = 0;
	localparam int CALL_LONG_BIT = 0;
	localparam int CALL_SHRT_BIT = 1;
	localparam logic [31:0] RX_MODE_WMASK = 32'h2000_0007;
	localparam logic [31:0] TX_MODE_WMASK = 32'h2000_0013;
	localparam logic [31:0] RX_MODE_RST   = 32'h0000_0000;
	localparam logic [31:0] TX_MODE_RST   = 32'h2000_0000;
	// interrupt status layout
	localparam int INT_W        = 5;
	localparam int INT_RX_START = 0;
	localparam int INT_TX_START = 1;
	localparam int INT_UNSEC_WR = 2;
	localparam int INT_BR_UNSEC = 3;
	localparam int INT_NO_BUF   = 4;
	// call result layout
	localparam int RES_W        = 3;
	localparam int RES_VIOL_BIT = 0;
	localparam int RES_NOBUF_BIT = 2;
	// logical buffer address layout
	localparam int         PFX_LSB     = 27;
	localparam int         PFX_W       = 5;
	localparam logic [4:0] BUF_PREFIX  = 5'h01;
	localparam logic [2:0] LONG_MARK   = 3'h4;
	localparam logic [1:0] SHORT_MARK  = 2'h0;
	localparam int         IDX_LSB     = 18;
	localparam int         LONG_IDX_W  = 6;
	localparam int         SHORT_IDX_W = 7;
	typedef enum logic [1:0] {SRC_CPU = 2'b00, SRC_MAC_DMA = 2'b01,
		SRC_BR_XFER = 2'b10, SRC_BR_INTBUF = 2'b11} emf_src_t;
	typedef enum logic [1:0] {GATE_IDLE = 2'b00, GATE_FILL = 2'b01,
		GATE_SENT = 2'b10} emf_gate_st_t;
	typedef enum logic [1:0] {BUF_NONE = 2'b00, BUF_LONG = 2'b01,
		BUF_SHORT = 2'b10} emf_buf_kind_t;
endpackage : emf_pkg

//--- verilog/emf_alloc_if.sv
// carrier between the register bank and the buffer allocator
`timescale 1ns/1ns
`default_nettype none
interface emf_alloc_if;
	logic        acq_long;
	logic        acq_short;
	logic        rel_valid;
	logic [31:0] rel_addr;
	logic [31:0] chk_addr;
	logic        rsp_valid;
	logic        rsp_ok;
	logic [31:0] rsp_addr;
	logic        chk_unsec;
	modport alloc (input acq_long, acq_short, rel_valid, rel_addr,
		chk_addr, output rsp_valid, rsp_ok, rsp_addr, chk_unsec);
	modport user (output acq_long, acq_short, rel_valid, rel_addr,
		chk_addr, input rsp_valid, rsp_ok, rsp_addr, chk_unsec);
endinterface : emf_alloc_if
`default_nettype wire

//--- verilog/emf_fwd_gate.sv
// start gate deciding when a fifo frame may be forwarded
`timescale 1ns/1ns
`default_nettype none
module emf_fwd_gate #(
	parameter int CNT_W = 12,
	parameter int THR_W = 3
) (
	input  wire logic             ref_clk,
	input  wire logic             arst_n,
	input  wire logic             saf_mode,
	input  wire logic [THR_W-1:0] start_thr,
	input  wire logic             word_wr,
	input  wire logic             frame_end,
	output logic                  start_r
);
	import emf_pkg::*;
	emf_gate_st_t     st_r, st_nxt;
	logic             mode_r;
	logic             mode_eff;
	logic             fire;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;

	// mode is sampled on the first word so a frame keeps its mode
	always_comb begin
		mode_eff = (st_r == GATE_IDLE) ? saf_mode : mode_r;
		cnt_nxt = ((st_r == GATE_IDLE) ? '0 : cnt_r) + CNT_W'(word_wr);
		fire = ((st_r == GATE_FILL) || word_wr) && (st_r != GATE_SENT)
			&& (frame_end || (!mode_eff && cnt_nxt >= CNT_W'(start_thr)));
		st_nxt = st_r;
		unique case (st_r)
			GATE_IDLE: if (word_wr && !frame_end) begin
				st_nxt = fire ? GATE_SENT : GATE_FILL;
			end
			GATE_FILL: if (frame_end) begin
				st_nxt = GATE_IDLE;
			end else if (fire) begin
				st_nxt = GATE_SENT;
			end
			GATE_SENT: if (frame_end) begin
				st_nxt = GATE_IDLE;
			end
			default: st_nxt = GATE_IDLE;
		endcase
	end

	// state, count, latched mode and the one-cycle start pulse
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= GATE_IDLE;
			cnt_r <= '0;
			mode_r <= 1'b0;
			start_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			mode_r <= mode_eff;
			start_r <= fire;
		end
	end
endmodule : emf_fwd_gate
`default_nettype wire

//--- verilog/emf_buf_alloc.sv
// buffer allocator: hands out long and short buffers, flags stray access
`timescale 1ns/1ns
`default_nettype none
module emf_buf_alloc #(
	parameter int LONG_N  = 64,
	parameter int SHORT_N = 128
) (
	input  wire logic  ref_clk,
	input  wire logic  arst_n,
	emf_alloc_if.alloc bus
);
	import emf_pkg::*;
	logic [LONG_N-1:0]    long_used_r;
	logic [SHORT_N-1:0]   short_used_r;
	logic [SHORT_IDX_W:0] ff_long, ff_short;
	emf_buf_kind_t        rel_kind, chk_kind;

	// lowest free slot; msb of the result says one was found
	function automatic logic [SHORT_IDX_W:0] first_free(
		input logic [SHORT_N-1:0] used);
		logic [SHORT_IDX_W:0] res;
		res = '0;
		for (int i = SHORT_N - 1; i >= 0; i--) begin
			if (!used[i]) res = {1'b1, SHORT_IDX_W'(i)};
		end
		return res;
	endfunction : first_free

	// which pool a logical address falls in
	function automatic emf_buf_kind_t buf_kind(input logic [31:0] a);
		emf_buf_kind_t k;
		k = BUF_NONE;
		if (a[PFX_LSB +: PFX_W] == BUF_PREFIX) begin
			if (a[PFX_LSB-1 -: 3] == LONG_MARK) k = BUF_LONG;
			else if (a[PFX_LSB-1 -: 2] == SHORT_MARK) k = BUF_SHORT;
		end
		return k;
	endfunction : buf_kind

	// long pool padded with used slots so one search serves both
	always_comb begin
		ff_long = first_free({{(SHORT_N-LONG_N){1'b1}}, long_used_r});
		ff_short = first_free(short_used_r);
		rel_kind = buf_kind(bus.rel_addr);
		chk_kind = buf_kind(bus.chk_addr);
		bus.chk_unsec = 1'b0;
		unique case (chk_kind)
			BUF_LONG: bus.chk_unsec =
				!long_used_r[bus.chk_addr[IDX_LSB +: LONG_IDX_W]];
			BUF_SHORT: bus.chk_unsec =
				!short_used_r[bus.chk_addr[IDX_LSB +: SHORT_IDX_W]];
			default: bus.chk_unsec = 1'b0;
		endcase
	end

	// ownership maps; release first, then the new grant
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			long_used_r <= '0;
			short_used_r <= '0;
		end else begin
			if (bus.rel_valid && rel_kind == BUF_LONG)
				long_used_r[bus.rel_addr[IDX_LSB +: LONG_IDX_W]] <= 1'b0;
			if (bus.rel_valid && rel_kind == BUF_SHORT)
				short_used_r[bus.rel_addr[IDX_LSB +: SHORT_IDX_W]] <= 1'b0;
			if (bus.acq_long && ff_long[SHORT_IDX_W])
				long_used_r[ff_long[LONG_IDX_W-1:0]] <= 1'b1;
			else if (bus.acq_short && ff_short[SHORT_IDX_W])
				short_used_r[ff_short[SHORT_IDX_W-1:0]] <= 1'b1;
		end
	end

	// start address of the granted buffer
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			bus.rsp_valid <= 1'b0;
			bus.rsp_ok <= 1'b0;
			bus.rsp_addr <= '0;
		end else begin
			bus.rsp_valid <= bus.acq_long || bus.acq_short;
			bus.rsp_ok <= bus.acq_long ? ff_long[SHORT_IDX_W]
				: ff_short[SHORT_IDX_W];
			bus.rsp_addr <= bus.acq_long
				? {BUF_PREFIX, LONG_MARK, ff_long[LONG_IDX_W-1:0],
					{IDX_LSB{1'b0}}}
				: {BUF_PREFIX, SHORT_MARK, ff_short[SHORT_IDX_W-1:0],
					{IDX_LSB{1'b0}}};
		end
	end
endmodule : emf_buf_alloc
`default_nettype wire

//--- sim/emf_frame_src.sv
// line-side frame source feeding the rx and tx fifo write strobes
`timescale 1ns/1ns
`default_nettype none
module emf_frame_src (
	input  wire logic       ref_clk,
	input  wire logic       arst_n,
	input  wire logic [1:0] go,
	input  wire logic [3:0] len,
	input  wire logic       stall,
	output logic [1:0]      word_wr,
	output logic [1:0]      frame_end
);
	logic [3:0] left_r [2];
	// channel 0 feeds rx, channel 1 feeds tx; stall slows the line
	for (genvar i = 0; i < 2; i++) begin : g_ch
		always_ff @(posedge ref_clk or negedge arst_n) begin
			if (!arst_n) begin
				left_r[i] <= 4'h0;
			end else if (go[i]) begin
				left_r[i] <= len;
			end else if (word_wr[i]) begin
				left_r[i] <= left_r[i] - 4'h1;
			end
		end
		// end mark rides on the last word, never alone
		assign word_wr[i]   = left_r[i] != 4'h0 && !stall;
		assign frame_end[i] = word_wr[i] && left_r[i] == 4'h1;
	end
endmodule : emf_frame_src
`default_nettype wire

//--- sim/emf_checker.sv
// port-level assertions for the mac forwarding and buffer block
`timescale 1ns/1ns
`default_nettype none
module emf_checker (
	input wire logic        ref_clk,
	input wire logic        arst_n,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic        avs_waitrequest,
	input wire logic        rx_word_wr,
	input wire logic        rx_frame_end,
	input wire logic        rx_dma_start,
	input wire logic        tx_frame_end,
	input wire logic        tx_start,
	input wire logic [31:0] phy_mgmt_ctrl,
	input wire logic        acc_valid,
	input wire logic        irq
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	// bus access steps: request rises, one low wait cycle, high again
	sequence req_rise_s;
		$rose(avs_read || avs_write);
	endsequence
	sequence one_wait_s;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence
	wait_accept_a: assert property (req_rise_s |=> one_wait_s)
		else $error("bus answer not one wait cycle");
	wait_idle_a: assert property (!(avs_read || avs_write) |-> avs_waitrequest)
		else $error("waitrequest low without request");
	rx_start_word_a: assert property (rx_dma_start |-> $past(rx_word_wr))
		else $error("rx start without a word");
	rx_start_once_a: assert property (
		rx_dma_start && !$past(rx_frame_end) |=> !rx_dma_start)
		else $error("rx start twice in a frame");
	tx_start_end_a: assert property (tx_start |-> $past(tx_frame_end))
		else $error("tx start before frame end");
	// irq only moves after an event or a register write
	irq_rise_a: assert property ($rose(irq) |-> rx_dma_start || tx_start
		|| $past(rx_dma_start || tx_start || acc_valid || avs_write)
		|| $past(avs_write, 2)) else $error("irq rose without cause");
	irq_fall_a: assert property (
		$fell(irq) |-> $past(avs_write) || $past(avs_write, 2))
		else $error("irq fell without write");
	mgmt_hold_a: assert property (
		!$stable(phy_mgmt_ctrl) |-> $past(avs_write) || $past(avs_write, 2))
		else $error("mgmt setting moved without write");
endmodule : emf_checker
bind emf_top emf_checker emf_checker_inst (.*);
`default_nettype wire

//--- sim/testbench.sv
// self-checking bench for the mac forwarding and buffer block
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import emf_pkg::*;
	logic        ref_clk       = 1'b0;
	logic        arst_n        = 1'b0;
	logic [5:0]  avs_address   = 6'h00;
	logic        avs_read      = 1'b0;
	logic        avs_write     = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic        acc_valid     = 1'b0;
	logic [31:0] acc_addr      = 32'h0;
	emf_src_t    acc_src       = SRC_CPU;
	logic [1:0]  go            = 2'h0;
	logic [3:0]  len           = 4'h0;
	logic        stall         = 1'b0;
	logic [1:0]  word_wr, frame_end;
	logic [31:0] avs_readdata, phy_mgmt_ctrl, rdata;
	logic        avs_waitrequest, rx_dma_start, tx_start, irq;
	logic        tx_long_frame_en, switch_tag_en;
	int          fail_count      = 0;
	int          samples_checked = 0;
	// 20 mhz reference clock
	always #25 ref_clk = ~ref_clk;
	emf_top emf_top_inst (.ref_clk(ref_clk), .arst_n(arst_n),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hf), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .rx_word_wr(word_wr[0]),
		.rx_frame_end(frame_end[0]), .rx_dma_start(rx_dma_start),
		.tx_word_wr(word_wr[1]), .tx_frame_end(frame_end[1]),
		.tx_start(tx_start), .tx_long_frame_en(tx_long_frame_en),
		.switch_tag_en(switch_tag_en), .phy_mgmt_ctrl(phy_mgmt_ctrl),
		.acc_valid(acc_valid), .acc_addr(acc_addr), .acc_src(acc_src),
		.irq(irq));
	emf_frame_src emf_frame_src_inst (.ref_clk(ref_clk), .arst_n(arst_n),
		.go(go), .len(len), .stall(stall), .word_wr(word_wr),
		.frame_end(frame_end));
	task automatic results;
		if (fail_count == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : results
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			$display("[ERR] %0t seen %h want %h", $time, seen, exp);
			fail_count++;
		end
	endtask : chk
	// request held until waitrequest is sampled low
	task automatic bus(input logic rd, input logic [5:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= rd;
		avs_write <= !rd;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			fail_count++;
			results();
		end
	endtask : bus
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		bus(1'b0, a, d, rdata);
	endtask : wr
	// one frame of l words, s stalled edges; exp counts edges from go
	task automatic frame(input int ch, input logic [3:0] l, input int s,
		input int exp);
		int n;
		@(posedge ref_clk);
		go[ch] <= 1'b1;
		len <= l;
		@(posedge ref_clk);
		go[ch] <= 1'b0;
		stall <= s > 0;
		n = 1;
		do begin
			@(posedge ref_clk);
			n++;
			if (n == s + 1) stall <= 1'b0;
		end while ((ch ? tx_start : rx_dma_start) !== 1'b1 && n < 40);
		chk(32'(n), 32'(exp));
		if (n == 40) results();
	endtask : frame
	task automatic acc(input emf_src_t s, input logic [31:0] a);
		@(posedge ref_clk);
		acc_valid <= 1'b1;
		acc_src <= s;
		acc_addr <= a;
		@(posedge ref_clk);
		acc_valid <= 1'b0;
		repeat (2) @(posedge ref_clk);
	endtask : acc
	task automatic t_regs;
		bus(1'b1, OFS_TX_MODE, 32'h0, rdata);
		chk(rdata, TX_MODE_RST);
		bus(1'b1, 6'h3c, 32'h0, rdata);
		chk(rdata, 32'h0);
		wr(OFS_PORT_SEL, 32'h0);
		wr(OFS_PHY_MGMT, 32'h1234_5678);
		repeat (2) @(posedge ref_clk);
		chk(phy_mgmt_ctrl, 32'h0);
		wr(OFS_PORT_SEL, 32'h1);
		wr(OFS_PHY_MGMT, 32'h1234_5678);
		repeat (2) @(posedge ref_clk);
		chk(phy_mgmt_ctrl, 32'h1234_5678);
	endtask : t_regs
	task automatic t_rx;
		wr(OFS_RX_MODE, 32'h2000_0000);
		frame(0, 4'd5, 0, 7);
		frame(0, 4'd4, 2, 8);
		wr(OFS_RX_MODE, 32'h0000_0003);
		frame(0, 4'd5, 0, 5);
		wr(OFS_RX_MODE, 32'h0000_0007);
		frame(0, 4'd4, 0, 6);
		wr(OFS_RX_MODE, 32'h0000_0000);
		frame(0, 4'd2, 0, 3);
		wr(OFS_RX_MODE, 32'h2000_0000);
		// mode flips mid-frame; the running frame keeps its mode
		fork
			frame(0, 4'd12, 0, 14);
			begin
				@(posedge ref_clk);
				wr(OFS_RX_MODE, 32'h0000_0001);
			end
		join
		frame(0, 4'd4, 0, 3);
	endtask : t_rx
	task automatic t_tx;
		wr(OFS_SW_TAG, 32'h1);
		wr(OFS_TX_MODE, 32'h2000_0012);
		repeat (2) @(posedge ref_clk);
		chk({30'h0, switch_tag_en, tx_long_frame_en}, 32'h3);
		frame(1, 4'd3, 0, 5);
		frame(1, 4'd1, 0, 3);
		// both start events are still latched in the status
		bus(1'b1, OFS_INT_STAT, 32'h0, rdata);
		chk(rdata, 32'h3);
	endtask : t_tx
	task automatic t_alloc;
		for (int i = 0; i < 2; i++) begin
			wr(OFS_CALL, 32'h1);
			repeat (3) @(posedge ref_clk);
			bus(1'b1, OFS_ACQ_ADDR, 32'h0, rdata);
			chk(rdata, {BUF_PREFIX, LONG_MARK, 6'(i), 18'h0});
			wr(OFS_CALL, 32'h2);
			repeat (3) @(posedge ref_clk);
			bus(1'b1, OFS_ACQ_ADDR, 32'h0, rdata);
			chk(rdata, {BUF_PREFIX, SHORT_MARK, 7'(i), 18'h0});
		end
		// freeing long slot 0 makes it the lowest free one again
		wr(OFS_RELEASE, {BUF_PREFIX, LONG_MARK, 6'h0, 18'h0});
		wr(OFS_CALL, 32'h1);
		repeat (3) @(posedge ref_clk);
		bus(1'b1, OFS_ACQ_ADDR, 32'h0, rdata);
		chk(rdata, {BUF_PREFIX, LONG_MARK, 6'h0, 18'h0});
	endtask : t_alloc
	task automatic t_irq;
		wr(OFS_INT_STAT, 32'h1f);
		wr(OFS_INT_MASK, 32'h0);
		// short slot 5 was never acquired
		for (int s = 0; s < 4; s++) begin
			acc(emf_src_t'(s), 32'h0814_0000);
			bus(1'b1, OFS_INT_STAT, 32'h0, rdata);
			chk(rdata, s < 2 ? 32'h4 : s == 3 ? 32'h8 : 32'h0);
			bus(1'b1, OFS_CALL_RES, 32'h0, rdata);
			chk(rdata, s == 2 ? 32'h1 : 32'h0);
			chk({31'h0, irq}, 32'h0);
			wr(OFS_INT_STAT, 32'h1f);
			wr(OFS_CALL_RES, 32'h7);
		end
		acc(SRC_MAC_DMA, 32'h0c00_0000);
		bus(1'b1, OFS_INT_STAT, 32'h0, rdata);
		chk(rdata, 32'h0);
		wr(OFS_INT_MASK, 32'h4);
		acc(SRC_CPU, 32'h0814_0000);
		chk({31'h0, irq}, 32'h1);
		wr(OFS_INT_STAT, 32'h4);
		@(posedge ref_clk);
		chk({31'h0, irq}, 32'h0);
	endtask : t_irq
	initial begin
		repeat (12) @(posedge ref_clk);
		arst_n <= 1'b1;
		t_regs();
		t_rx();
		t_tx();
		t_alloc();
		t_irq();
		results();
	end
endmodule : testbench
`default_nettype wire
